/* File: hw/tcbp_defines.vh */
// constants for the tape cache buffer policy block
// What this block does, except RQ4 to RQ6, which concern the host
// RQ1: descriptor reply of the buffer-read command is exactly four bytes long.
// RQ2: nonzero buffer identifier yields four zero bytes.
// RQ3: reply byte 0 is zero, then 24-bit capacity, most significant first.
// RQ4: host sustains average rate matching density and speed to stream.
// RQ5: host protocol time per repeated write stays under the reinstruct budget.
// RQ6: timing budget assumes two message phases and six-byte command block.
// RQ7: prefetch qualifier is disabled or after 1, 2 or 3 reads.
// RQ8: only back-to-back reads count; any other command restarts the count.
// RQ9: prefetch stops on one filemark, two filemarks, or continues.
// RQ10: after a filemark halt, prefetch waits for fresh qualification.
// RQ11: buffered mode holds 1, 2, 4, 8 or 16 write blocks before motion.
// RQ12: one complete write block always lands in cache before motion.
// RQ13: partial hold is forced to tape after 250 ms.
// RQ14: verify mode reads written data from the tape.
// RQ15: cache mode serves written data still buffered without tape motion.
// RQ16: cache mode reverse read returns reverse order, forward read forward.
// RQ17: verify mode forward read after reverse tape read comes from cache.
// RQ18: a configurable maximum block length limits accepted blocks.
// RQ19: limits are 32K, 64K, 128K, 256K (261887 bytes) or full cache.
// RQ20: prefetch pauses while the cache has no room for a block.
`ifndef TCBP_DEFINES_VH
`define TCBP_DEFINES_VH

// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define TCBP_A_CTRL      4'h0
`define TCBP_A_STATUS    4'h1
`define TCBP_A_CAPACITY  4'h2
`define TCBP_A_WRCOUNT   4'h3

// ---------------------------------------------------------------
// control field positions
// ---------------------------------------------------------------
`define TCBP_F_QUAL_LO   0
`define TCBP_F_QUAL_HI   1
`define TCBP_F_STOP_LO   2
`define TCBP_F_STOP_HI   3
`define TCBP_F_HOLD_LO   4
`define TCBP_F_HOLD_HI   6
`define TCBP_F_CACHE     7
`define TCBP_F_MAX_LO    8
`define TCBP_F_MAX_HI    10
`define TCBP_F_BUFFERED  11
`define TCBP_CTRL_RST    12'h000

// ---------------------------------------------------------------
// option encodings
// ---------------------------------------------------------------
`define TCBP_STOP_CONT   2'h0
`define TCBP_STOP_ONE    2'h1
`define TCBP_STOP_TWO    2'h2
`define TCBP_MAX_32K     3'h0
`define TCBP_MAX_64K     3'h1
`define TCBP_MAX_128K    3'h2
`define TCBP_MAX_256K    3'h3
`define TCBP_LEN_32K     24'h008000
`define TCBP_LEN_64K     24'h010000
`define TCBP_LEN_128K    24'h020000
`define TCBP_LEN_256K    24'h03FEFF
`define TCBP_HOLD_MAX    3'h4

// ---------------------------------------------------------------
// descriptor reply and cache geometry
// ---------------------------------------------------------------
`define TCBP_DESC_MODE   2'h3
`define TCBP_DESC_LEN    3'h4
`define TCBP_CAP_BYTES   24'h040000
`define TCBP_SLOTS       32
`define TCBP_SLOT_W      5
`define TCBP_CNT_W       6

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define TCBP_FLUSH_MS    250
`define TCBP_CLK_MHZ     100
`define TCBP_FLUSH_CYC   (`TCBP_FLUSH_MS * 1000 * `TCBP_CLK_MHZ)

`endif

/* File: hw/tcbp_desc_reply.v */
// byte sequencer for the descriptor form of the buffer-read reply
`timescale 1ns/100ps
`default_nettype none
`include "tcbp_defines.vh"

module tcbp_desc_reply (
  // clock and reset
  input  wire        sys_clk,
  input  wire        rst_n,
  // request
  input  wire        start,
  input  wire [7:0]  buffer_id,
  input  wire [23:0] capacity,
  // byte stream to the bus engine
  output reg  [7:0]  byte_data_r,
  output reg         byte_valid_r,
  output reg         byte_last_r
);

  reg  [2:0]  idx_r;
  reg         busy_r;
  reg  [23:0] cap_r;
  reg  [7:0]  b_nxt;

  // reply byte select; nonzero id gives zeros, capacity msb first
  always @* begin
    case (idx_r)
      3'h0:    b_nxt = 8'h00;                 // [RQ3]
      3'h1:    b_nxt = cap_r[23:16];          // [RQ3]
      3'h2:    b_nxt = cap_r[15:8];
      3'h3:    b_nxt = cap_r[7:0];
      default: b_nxt = 8'h00;
    endcase
  end

  // count exactly four bytes regardless of allocation length
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      idx_r        <= 3'h0;
      busy_r       <= 1'b0;
      cap_r        <= 24'h000000;
      byte_data_r  <= 8'h00;
      byte_valid_r <= 1'b0;
      byte_last_r  <= 1'b0;
    end else if (!busy_r) begin
      byte_valid_r <= 1'b0;
      byte_last_r  <= 1'b0;
      if (start) begin
        busy_r <= 1'b1;
        idx_r  <= 3'h0;
        cap_r  <= (buffer_id != 8'h00) ? 24'h000000 : capacity; // [RQ2]
      end
    end else begin
      byte_data_r  <= b_nxt;
      byte_valid_r <= 1'b1;
      byte_last_r  <= (idx_r == `TCBP_DESC_LEN - 3'h1);           // [RQ1]
      idx_r        <= idx_r + 3'h1;
      if (idx_r == `TCBP_DESC_LEN - 3'h1)
        busy_r <= 1'b0;                                          // [RQ1]
    end
  end

endmodule // tcbp_desc_reply
`default_nettype wire

/* File: hw/tcbp_policy.v */
// cache and buffer policy core of the tape target controller
`timescale 1ns/100ps
`default_nettype none
`include "tcbp_defines.vh"

module tcbp_policy #(
  parameter FLUSH_CYCLES = `TCBP_FLUSH_CYC
) (
  // clock and reset
  input  wire        sys_clk,
  input  wire        rst_n,
  // register port
  input  wire [3:0]  reg_addr,
  input  wire [31:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [31:0] reg_rdata_r,
  // host command events, one-cycle pulses
  input  wire        cmd_read,
  input  wire        cmd_read_rev,
  input  wire        cmd_write,
  input  wire        cmd_other,
  input  wire        wr_block_done,
  input  wire [23:0] wr_block_len,
  // tape side events, one-cycle pulses
  input  wire        tape_filemark,
  input  wire        tape_block_read,
  input  wire        tape_flush_done,
  // descriptor request
  input  wire        desc_start,
  input  wire [1:0]  desc_mode,
  input  wire [7:0]  desc_buffer_id,
  // policy outputs
  output reg         prefetch_run_r,
  output reg         tape_write_go_r,
  output reg         block_reject_r,
  output reg         read_from_cache_r,
  output reg         read_reverse_order_r,
  output reg         tape_read_go_r,
  output wire [7:0]  desc_byte,
  output wire        desc_valid,
  output wire        desc_last
);

  // -------------------------------------------------------------
  // configuration register
  // -------------------------------------------------------------
  reg  [11:0] ctrl_r;
  wire [1:0]  qual_sel   = ctrl_r[`TCBP_F_QUAL_HI:`TCBP_F_QUAL_LO];
  wire [1:0]  stop_sel   = ctrl_r[`TCBP_F_STOP_HI:`TCBP_F_STOP_LO];
  wire [2:0]  hold_sel   = ctrl_r[`TCBP_F_HOLD_HI:`TCBP_F_HOLD_LO];
  wire        cache_mode = ctrl_r[`TCBP_F_CACHE];
  wire [2:0]  max_sel    = ctrl_r[`TCBP_F_MAX_HI:`TCBP_F_MAX_LO];
  wire        buffered   = ctrl_r[`TCBP_F_BUFFERED];

  // -------------------------------------------------------------
  // state
  // -------------------------------------------------------------
  reg  [1:0]             qual_cnt_r;
  reg                    pf_armed_r;
  reg                    fm_seen_r;
  reg  [`TCBP_CNT_W-1:0] held_r;
  reg  [`TCBP_CNT_W-1:0] used_r;
  reg  [`TCBP_CNT_W-1:0] written_r;
  reg  [27:0]            flush_cnt_r;
  reg                    flushing_r;
  reg                    rev_loaded_r;

  wire [`TCBP_CNT_W-1:0] hold_lim;
  wire [23:0]            max_len;
  wire                   cache_full;
  wire                   any_read;
  wire                   hold_hit;
  wire                   flush_tmo;

  // hold limit as a power of two, clamped at sixteen
  assign hold_lim = (hold_sel > `TCBP_HOLD_MAX) ?
                    (`TCBP_CNT_W'h01 << `TCBP_HOLD_MAX) :
                    (`TCBP_CNT_W'h01 << hold_sel);                // [RQ11]

  // maximum accepted block length
  assign max_len = (max_sel == `TCBP_MAX_32K)  ? `TCBP_LEN_32K  :
                   (max_sel == `TCBP_MAX_64K)  ? `TCBP_LEN_64K  :
                   (max_sel == `TCBP_MAX_128K) ? `TCBP_LEN_128K :
                   (max_sel == `TCBP_MAX_256K) ? `TCBP_LEN_256K :
                   `TCBP_CAP_BYTES;                              // [RQ19]

  assign cache_full = (used_r == `TCBP_SLOTS);                   // [RQ20]
  assign any_read   = cmd_read | cmd_read_rev;
  assign hold_hit   = (held_r >= hold_lim);
  assign flush_tmo  = (held_r != `TCBP_CNT_W'h00) &&
                      (flush_cnt_r == FLUSH_CYCLES - 1);         // [RQ13]

  // -------------------------------------------------------------
  // register port
  // -------------------------------------------------------------
  // one cycle read latency; unmapped addresses read zero
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      ctrl_r      <= `TCBP_CTRL_RST;
      reg_rdata_r <= 32'h00000000;
    end else begin
      if (reg_wr && reg_addr == `TCBP_A_CTRL)
        ctrl_r <= reg_wdata[11:0];
      reg_rdata_r <= 32'h00000000;
      if (reg_rd) begin
        case (reg_addr)
          `TCBP_A_CTRL:     reg_rdata_r <= {20'h00000, ctrl_r};
          `TCBP_A_STATUS:   reg_rdata_r <= {16'h0000, used_r, held_r,
                                            pf_armed_r, flushing_r,
                                            prefetch_run_r, fm_seen_r};
          `TCBP_A_CAPACITY: reg_rdata_r <= {8'h00, `TCBP_CAP_BYTES};
          `TCBP_A_WRCOUNT:  reg_rdata_r <= {26'h0000000, written_r};
          default:          reg_rdata_r <= 32'h00000000;
        endcase
      end
    end
  end

  // -------------------------------------------------------------
  // prefetch qualification and filemark stop
  // -------------------------------------------------------------
  // a reset count on a non-read keeps stale reads from arming prefetch
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      qual_cnt_r     <= 2'h0;
      pf_armed_r     <= 1'b0;
      fm_seen_r      <= 1'b0;
      prefetch_run_r <= 1'b0;
    end else begin
      if (cmd_write || cmd_other) begin
        qual_cnt_r <= 2'h0;                                      // [RQ8]
        pf_armed_r <= 1'b0;                                      // [RQ8]
      end else if (any_read && qual_sel != 2'h0 && !pf_armed_r) begin
        if (qual_cnt_r + 2'h1 >= qual_sel) begin
          pf_armed_r <= 1'b1;                                    // [RQ7]
          qual_cnt_r <= 2'h0;
        end else begin
          qual_cnt_r <= qual_cnt_r + 2'h1;                       // [RQ8]
        end
      end
      if (qual_sel == 2'h0)
        pf_armed_r <= 1'b0;                                      // [RQ7]
      // filemark handling; a halt disarms until requalified
      if (tape_filemark && prefetch_run_r) begin
        if (stop_sel == `TCBP_STOP_ONE ||
            (stop_sel == `TCBP_STOP_TWO && fm_seen_r)) begin
          pf_armed_r <= 1'b0;                                    // [RQ9]
          qual_cnt_r <= 2'h0;                                    // [RQ10]
          fm_seen_r  <= 1'b0;
        end else if (stop_sel == `TCBP_STOP_TWO) begin
          fm_seen_r <= 1'b1;                                     // [RQ9]
        end
      end else if (tape_block_read) begin
        fm_seen_r <= 1'b0;         // only consecutive marks count
      end
      prefetch_run_r <= pf_armed_r && !cache_full && !held_r[0] &&
                        (held_r == `TCBP_CNT_W'h00);             // [RQ20]
    end
  end

  // -------------------------------------------------------------
  // write hold and forced flush
  // -------------------------------------------------------------
  // motion starts only after a whole block is in cache
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      held_r          <= `TCBP_CNT_W'h00;
      written_r       <= `TCBP_CNT_W'h00;
      flush_cnt_r     <= 28'h0000000;
      flushing_r      <= 1'b0;
      tape_write_go_r <= 1'b0;
      block_reject_r  <= 1'b0;
    end else begin
      tape_write_go_r <= 1'b0;
      block_reject_r  <= 1'b0;
      if (wr_block_done) begin
        if (wr_block_len > max_len) begin
          block_reject_r <= 1'b1;                                // [RQ18]
        end else if (!cache_full) begin
          held_r    <= held_r + `TCBP_CNT_W'h01;                 // [RQ12]
          if (written_r != `TCBP_SLOTS)
            written_r <= written_r + `TCBP_CNT_W'h01;
        end
      end
      if (cmd_write && !wr_block_done && held_r == `TCBP_CNT_W'h00)
        written_r <= `TCBP_CNT_W'h00;
      // timer runs only while a partial hold waits
      if (held_r == `TCBP_CNT_W'h00 || flushing_r)
        flush_cnt_r <= 28'h0000000;
      else if (!flush_tmo)
        flush_cnt_r <= flush_cnt_r + 28'h0000001;
      if (!flushing_r && held_r != `TCBP_CNT_W'h00 &&
          (!buffered || hold_hit || flush_tmo)) begin
        flushing_r      <= 1'b1;                                 // [RQ11]
        tape_write_go_r <= 1'b1;                                 // [RQ13]
      end
      if (flushing_r && tape_flush_done) begin
        flushing_r <= 1'b0;
        held_r     <= wr_block_done ? `TCBP_CNT_W'h01 : `TCBP_CNT_W'h00;
      end
    end
  end

  // -------------------------------------------------------------
  // cache occupancy
  // -------------------------------------------------------------
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      used_r <= `TCBP_CNT_W'h00;
    end else if (tape_block_read && !cache_full && !any_read) begin
      used_r <= used_r + `TCBP_CNT_W'h01;
    end else if (any_read && used_r != `TCBP_CNT_W'h00 &&
                 !tape_block_read) begin
      used_r <= used_r - `TCBP_CNT_W'h01;           // space released
    end
  end

  // -------------------------------------------------------------
  // read source selection
  // -------------------------------------------------------------
  // written data stays serviceable from cache only in cache mode
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      read_from_cache_r    <= 1'b0;
      read_reverse_order_r <= 1'b0;
      tape_read_go_r       <= 1'b0;
      rev_loaded_r         <= 1'b0;
    end else begin
      tape_read_go_r <= 1'b0;
      if (cmd_write)
        rev_loaded_r <= 1'b0;
      if (cmd_read_rev) begin
        read_reverse_order_r <= 1'b1;                            // [RQ16]
        if (cache_mode && written_r != `TCBP_CNT_W'h00) begin
          read_from_cache_r <= 1'b1;                             // [RQ15]
        end else begin
          read_from_cache_r <= 1'b0;                             // [RQ14]
          tape_read_go_r    <= 1'b1;                             // [RQ14]
          rev_loaded_r      <= 1'b1;
        end
      end else if (cmd_read) begin
        read_reverse_order_r <= 1'b0;                            // [RQ16]
        if (cache_mode && written_r != `TCBP_CNT_W'h00) begin
          read_from_cache_r <= 1'b1;                             // [RQ15]
        end else if (rev_loaded_r) begin
          read_from_cache_r <= 1'b1;                             // [RQ17]
        end else begin
          read_from_cache_r <= 1'b0;                             // [RQ14]
          tape_read_go_r    <= 1'b1;
        end
      end
    end
  end

  // -------------------------------------------------------------
  // descriptor reply
  // -------------------------------------------------------------
  tcbp_desc_reply u_desc (
    .sys_clk      (sys_clk),
    .rst_n        (rst_n),
    .start        (desc_start && desc_mode == `TCBP_DESC_MODE),  // [RQ1]
    .buffer_id    (desc_buffer_id),
    .capacity     (`TCBP_CAP_BYTES),
    .byte_data_r  (desc_byte),
    .byte_valid_r (desc_valid),
    .byte_last_r  (desc_last)
  );

endmodule // tcbp_policy
`default_nettype wire

/* File: sim/tcbp_policy_sva.sv */
// concurrent checks for the tape cache buffer policy block
`timescale 1ns/100ps
`default_nettype none
`include "tcbp_defines.vh"

module tcbp_policy_sva #(
  parameter FLUSH_CYCLES = 50
) (
  // clock and reset
  input wire logic        sys_clk,
  input wire logic        rst_n,
  // register writes
  input wire logic [3:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  // host and tape events
  input wire logic        cmd_write,
  input wire logic        wr_block_done,
  input wire logic [23:0] wr_block_len,
  input wire logic        tape_filemark,
  input wire logic        desc_start,
  input wire logic [1:0]  desc_mode,
  input wire logic [7:0]  desc_buffer_id,
  // policy outputs
  input wire logic        prefetch_run_r,
  input wire logic        block_reject_r,
  input wire logic [7:0]  desc_byte,
  input wire logic        desc_valid,
  input wire logic        desc_last
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  logic [11:0] ctrl_r;
  logic [23:0] max_len;
  logic        id_nz_r;
  // control word rebuilt from writes, as no register is visible here
  always_ff @(posedge sys_clk)
    if (!rst_n)
      ctrl_r <= 12'h000;
    else if (reg_wr && reg_addr == `TCBP_A_CTRL)
      ctrl_r <= reg_wdata[11:0];
  // length ceiling of the selected setting
  assign max_len = (ctrl_r[10:8] == `TCBP_MAX_32K)  ? `TCBP_LEN_32K :
                   (ctrl_r[10:8] == `TCBP_MAX_64K)  ? `TCBP_LEN_64K :
                   (ctrl_r[10:8] == `TCBP_MAX_128K) ? `TCBP_LEN_128K :
                   (ctrl_r[10:8] == `TCBP_MAX_256K) ? `TCBP_LEN_256K :
                   `TCBP_CAP_BYTES;
  // which buffer the taken request named; starts while desc_valid is high are ignored
  always_ff @(posedge sys_clk)
    if (desc_start && desc_mode == `TCBP_DESC_MODE && !desc_valid)
      id_nz_r <= desc_buffer_id != 8'h00;

  a_desc_four_beats: assert property (
    $rose(desc_valid) |-> desc_valid [*4] ##1 !desc_valid)
    else $error("reply length wrong");
  a_desc_last_fourth: assert property (
    $rose(desc_valid) |-> !desc_last [*3] ##1 desc_last)
    else $error("last flag misplaced");
  a_desc_zero_id: assert property (
    $rose(desc_valid) && id_nz_r |-> (desc_byte == 8'h00) [*4])
    else $error("nonzero id gave data");
  a_desc_capacity: assert property (
    $rose(desc_valid) && !id_nz_r |-> desc_byte == 8'h00
    ##1 desc_byte == 8'h04 ##1 desc_byte == 8'h00 ##1 desc_byte == 8'h00)
    else $error("capacity bytes wrong");
  a_block_too_long: assert property (
    wr_block_done && wr_block_len > max_len |=> block_reject_r)
    else $error("oversize block kept");
  a_block_in_limit: assert property (
    wr_block_done && wr_block_len <= max_len |=> !block_reject_r)
    else $error("legal block refused");
  a_write_restarts: assert property (
    cmd_write |-> ##3 !prefetch_run_r)
    else $error("write kept prefetch");
  a_fm_halt: assert property (
    tape_filemark && prefetch_run_r && ctrl_r[3:2] == `TCBP_STOP_ONE
    |-> ##3 !prefetch_run_r)
    else $error("filemark did not halt");
endmodule // tcbp_policy_sva

bind tcbp_policy tcbp_policy_sva #(.FLUSH_CYCLES(FLUSH_CYCLES))
  tcbp_policy_sva_inst (.sys_clk(sys_clk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .cmd_write(cmd_write), .wr_block_done(wr_block_done),
    .wr_block_len(wr_block_len), .tape_filemark(tape_filemark),
    .desc_start(desc_start), .desc_mode(desc_mode),
    .desc_buffer_id(desc_buffer_id), .prefetch_run_r(prefetch_run_r),
    .block_reject_r(block_reject_r), .desc_byte(desc_byte),
    .desc_valid(desc_valid), .desc_last(desc_last));
`default_nettype wire

/* File: sim/tcbp_host.sv */
// host initiator and tape event model facing the policy block
`timescale 1ns/100ps
`default_nettype none
`include "tcbp_defines.vh"

module tcbp_host (
  // clock
  input  wire logic        sys_clk,
  // events: read, reverse, write, other, block, filemark, tape read, flushed
  output var  logic [7:0]  pulse_r,
  output var  logic [23:0] wr_block_len,
  // descriptor request
  output var  logic        desc_start,
  output var  logic [1:0]  desc_mode,
  output var  logic [7:0]  desc_buffer_id
);
  // quiet bus at time zero
  initial begin
    pulse_r = 8'h00;
    wr_block_len = 24'h000000;
    desc_start = 1'b0;
    desc_mode = 2'h0;
    desc_buffer_id = 8'h00;
  end
  // one-cycle event; the next call waits a fresh edge before raising again
  task automatic pulse(input int k);
    @(posedge sys_clk);
    pulse_r <= 8'h01 << k;
    @(posedge sys_clk);
    pulse_r <= 8'h00;
  endtask
  // callers pace blocks like a host that keeps the tape streaming
  task automatic block(input logic [23:0] len);
    @(posedge sys_clk);
    wr_block_len <= len;
    pulse_r <= 8'h10;
    @(posedge sys_clk);
    pulse_r <= 8'h00;
    wr_block_len <= ~len; // stale length is scrambled once taken
  endtask
  // one request stands for a whole six-byte command exchange
  task automatic desc(input logic [7:0] id);
    @(posedge sys_clk);
    desc_start <= 1'b1;
    desc_mode <= `TCBP_DESC_MODE;
    desc_buffer_id <= id;
    @(posedge sys_clk);
    desc_start <= 1'b0;
    desc_mode <= 2'h0;
    desc_buffer_id <= ~id;
  endtask
endmodule // tcbp_host
`default_nettype wire

/* File: sim/testbench.sv */
// self-checking bench for the tape cache buffer policy block
`timescale 1ns/100ps
`default_nettype none
`include "tcbp_defines.vh"

module testbench;
  localparam int FLUSH = 50; // short flush timeout keeps the run brief
  logic        sys_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [3:0]  reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  wire  [31:0] reg_rdata_r;
  wire  [23:0] wr_block_len;
  wire  [7:0]  pulse_r, desc_buffer_id, desc_byte;
  wire  [1:0]  desc_mode;
  wire         desc_start, desc_valid, desc_last, prefetch_run_r;
  wire         tape_write_go_r, block_reject_r, tape_read_go_r;
  wire         read_from_cache_r, read_reverse_order_r;
  int          n_mismatch = 0, checks = 0, n_go = 0, n_rgo = 0, n_rej = 0;
  int          g, r, t;
  logic [23:0] lens [6] = '{24'h008001, 24'h008000, 24'h010001,
                            24'h020000, 24'h03FF00, 24'h03FF00};

  tcbp_host tcbp_host_inst (.sys_clk(sys_clk), .pulse_r(pulse_r),
    .wr_block_len(wr_block_len), .desc_start(desc_start),
    .desc_mode(desc_mode), .desc_buffer_id(desc_buffer_id));
  tcbp_policy #(.FLUSH_CYCLES(FLUSH)) tcbp_policy_inst (
    .sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata_r(reg_rdata_r), .wr_block_len(wr_block_len),
    .desc_start(desc_start), .desc_mode(desc_mode),
    .desc_buffer_id(desc_buffer_id), .prefetch_run_r(prefetch_run_r),
    .tape_write_go_r(tape_write_go_r), .block_reject_r(block_reject_r),
    .read_from_cache_r(read_from_cache_r),
    .read_reverse_order_r(read_reverse_order_r),
    .tape_read_go_r(tape_read_go_r), .desc_byte(desc_byte),
    .desc_valid(desc_valid), .desc_last(desc_last),
    .cmd_read(pulse_r[0]), .cmd_read_rev(pulse_r[1]),
    .cmd_write(pulse_r[2]), .cmd_other(pulse_r[3]),
    .wr_block_done(pulse_r[4]), .tape_filemark(pulse_r[5]),
    .tape_block_read(pulse_r[6]), .tape_flush_done(pulse_r[7]));

  always #5 sys_clk = ~sys_clk;
  // tally one-cycle outputs so tests compare counts afterwards
  always @(posedge sys_clk) begin
    if (tape_write_go_r === 1'b1) n_go <= n_go + 1;
    if (tape_read_go_r === 1'b1) n_rgo <= n_rgo + 1;
    if (block_reject_r === 1'b1) n_rej <= n_rej + 1;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata_r, exp);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  // collect a descriptor reply that ends within the eight cycles after the request
  task automatic dchk(input logic [7:0] id, input logic [31:0] exp);
    logic [31:0] got;
    logic [3:0]  lastv;
    int          nb;
    got = 32'h0;
    lastv = 4'h0;
    nb = 0;
    tcbp_host_inst.desc(id);
    repeat (8) begin
      @(posedge sys_clk);
      #1;
      if (desc_valid === 1'b1) begin
        got = {got[23:0], desc_byte};
        lastv = {lastv[2:0], desc_last};
        nb++;
      end
    end
    chk(nb, 4);
    chk(got, exp);
    chk(lastv, 4'h1);
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // tests need about 500 cycles; sixty times that cuts a hang
  initial begin
    #300us;
    n_mismatch++;
    results();
  end

  initial begin
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd(`TCBP_A_CTRL, 32'h0);
    rd(`TCBP_A_CAPACITY, 32'h00040000);
    rd(4'hF, 32'h0);
    wr(`TCBP_A_CTRL, 32'h00000A26);
    rd(`TCBP_A_CTRL, 32'h00000A26);
    $display("test registers done");
    dchk(8'h00, 32'h00040000);
    dchk(8'h05, 32'h00000000);
    $display("test descriptor done");
    // every qualifier count, with a write breaking the first run
    for (int q = 0; q < 4; q++) begin
      wr(`TCBP_A_CTRL, q);
      tcbp_host_inst.pulse(3);
      repeat (q == 0 ? 3 : q - 1) tcbp_host_inst.pulse(0);
      tcbp_host_inst.pulse(2);
      repeat (q == 0 ? 3 : q - 1) tcbp_host_inst.pulse(0);
      cyc(3);
      chk(prefetch_run_r, 1'b0);
      tcbp_host_inst.pulse(0);
      cyc(3);
      chk(prefetch_run_r, q != 0);
    end
    $display("test prefetch qualify done");
    // filemark options: carry on, one, two
    for (int s = 0; s < 3; s++) begin
      wr(`TCBP_A_CTRL, 32'h1 | (s << 2));
      tcbp_host_inst.pulse(3);
      tcbp_host_inst.pulse(0);
      tcbp_host_inst.pulse(5);
      cyc(3);
      chk(prefetch_run_r, s != 1);
      tcbp_host_inst.pulse(5);
      cyc(8);
      chk(prefetch_run_r, s == 0);
      tcbp_host_inst.pulse(0);
      cyc(3);
      chk(prefetch_run_r, 1'b1);
    end
    $display("test filemark done");
    // one byte over 32K, 64K and 256K; exactly at 32K and 128K; under the full cache
    for (int i = 0; i < 6; i++) begin
      r = n_rej;
      wr(`TCBP_A_CTRL, 32'h840 | ((i == 0 ? 0 : i - 1) << 8));
      tcbp_host_inst.block(lens[i]);
      cyc(3);
      chk(n_rej - r, i % 2 == 0);
    end
    cyc(FLUSH + 10);
    tcbp_host_inst.pulse(7);
    $display("test block length done");
    // every hold limit: no motion one block short, motion at the limit
    for (int k = 0; k < 5; k++) begin
      wr(`TCBP_A_CTRL, 32'h800 | (k << 4));
      g = n_go;
      repeat ((1 << k) - 1) tcbp_host_inst.block(24'h000400);
      cyc(2);
      chk(n_go - g, 0);
      tcbp_host_inst.block(24'h000400);
      cyc(3);
      chk(n_go - g, 1);
      tcbp_host_inst.pulse(7);
    end
    // a partial hold is forced out by the timeout
    wr(`TCBP_A_CTRL, 32'h840);
    g = n_go;
    tcbp_host_inst.block(24'h000400);
    for (t = 0; t < 200 && n_go == g; t++) cyc(1);
    chk(t >= FLUSH - 5 && t <= FLUSH + 5, 1'b1);
    tcbp_host_inst.pulse(7);
    $display("test write hold done");
    // cache mode: reverse then forward from the buffer, tape still
    wr(`TCBP_A_CTRL, 32'h880);
    tcbp_host_inst.pulse(2);
    tcbp_host_inst.block(24'h000400);
    cyc(3);
    tcbp_host_inst.pulse(7);
    g = n_rgo;
    tcbp_host_inst.pulse(1);
    cyc(3);
    chk({read_from_cache_r, read_reverse_order_r}, 2'b11);
    tcbp_host_inst.pulse(0);
    cyc(3);
    chk({read_from_cache_r, read_reverse_order_r}, 2'b10);
    chk(n_rgo - g, 0);
    // verify mode: reverse moves tape, forward then from the buffer
    wr(`TCBP_A_CTRL, 32'h800);
    tcbp_host_inst.pulse(2);
    tcbp_host_inst.block(24'h000400);
    cyc(3);
    tcbp_host_inst.pulse(7);
    tcbp_host_inst.pulse(1);
    cyc(3);
    chk(n_rgo - g, 1);
    tcbp_host_inst.pulse(6);
    tcbp_host_inst.pulse(0);
    cyc(3);
    chk({read_from_cache_r, n_rgo - g == 1}, 2'b11);
    $display("test read source done");
    results();
  end
endmodule // testbench
`default_nettype wire
